// ---- clock_mode_cfg.svh ----
// Constants for the clock mode selection block.
// Assumes an 8-bit register port and an 8-bit configuration word.
`ifndef CLOCK_MODE_CFG_SVH
`define CLOCK_MODE_CFG_SVH

`define TRIM_ADDR 8'h00
`define STATUS_ADDR 8'h01
`define TRIM_WIDTH 5
`define TRIM_RESET 5'h00
`define TRIM_LEVEL_RESET 5'h10
`define TRIM_SIGN_BIT 4
`define CFG_MODE_LSB 0
`define CFG_MODE_MSB 2
`define CFG_FREQ_BIT 7
`define STAT_MODE_LSB 0
`define STAT_GAIN_LSB 3
`define STAT_DONE_BIT 5
`define STAT_EXEC_BIT 6
`define STAT_FREQ_BIT 7
`define STARTUP_CNT_W 11
`define STARTUP_LAST 11'h3ff
`define DIV_CNT_W 2
`define MODE_MAP_DEFAULT 24'hfac688

`endif

// ---- clock_mode_pkg.sv ----
// Types for the clock mode selection block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package clock_mode_pkg;

    typedef enum logic [2:0] {
        external_clock_mode = 3'b000,
        low_power_crystal_mode = 3'b001,
        medium_gain_crystal_mode = 3'b010,
        high_gain_crystal_mode = 3'b011,
        rc_with_clock_out_mode = 3'b100,
        rc_with_io_mode = 3'b101,
        internal_with_clock_out_mode = 3'b110,
        internal_with_io_mode = 3'b111
    } clock_mode_t;

    typedef enum logic [1:0] {
        gain_off = 2'b00,
        gain_low = 2'b01,
        gain_medium = 2'b10,
        gain_high = 2'b11
    } amp_gain_t;

    typedef enum logic [1:0] {
        source_pin = 2'b00,
        source_crystal = 2'b01,
        source_rc = 2'b10,
        source_internal = 2'b11
    } clock_source_t;

endpackage : clock_mode_pkg
`default_nettype wire

// ---- clock_mode_select.sv ----
// Clock mode selection: pin roles, amplifier gain, start-up gating, trim.
// Assumes cfg_word is a static fuse word and first_oscillator_pin_in an asynchronous pin.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "clock_mode_cfg.svh"

module clock_mode_select #(
    parameter logic [23:0] MODE_MAP = `MODE_MAP_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_bor_rst_n,
    input wire logic [7:0] cfg_word,
    input wire logic first_oscillator_pin_in,
    input wire logic sleep_active,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output var logic [7:0] reg_rdata,
    output var logic [1:0] sys_clk_src,
    output var logic [1:0] amp_gain,
    output var logic int_osc_en,
    output var logic int_8mhz,
    output var logic [4:0] trim_value,
    output var logic [4:0] trim_level,
    output var logic first_oscillator_pin_gpio_en,
    output var logic second_oscillator_pin_gpio_en,
    output var logic second_oscillator_pin_out,
    output var logic second_oscillator_pin_oe_n,
    output var logic exec_enable
);

    logic rst_meta_reg;
    logic rst_sync_n;
    logic por_meta_reg;
    logic por_sync_n;
    logic first_oscillator_pin_meta_reg;
    logic first_oscillator_pin_sync_reg;
    logic first_oscillator_pin_prev_reg;
    logic first_oscillator_pin_edge;
    logic cfg_valid_reg;
    logic cfg_load;
    logic freq_sel_reg;
    logic sleep_prev_reg;
    logic wake;
    logic startup_done;
    logic clk_div4;
    logic div_run;
    clock_mode_pkg::clock_mode_t mode_reg;

    function automatic clock_mode_pkg::clock_mode_t decode_mode(input logic [2:0] code);
        decode_mode = clock_mode_pkg::clock_mode_t'(MODE_MAP[3*code +: 3]);
    endfunction : decode_mode

    function automatic logic is_crystal(input clock_mode_pkg::clock_mode_t m);
        is_crystal = (m == clock_mode_pkg::low_power_crystal_mode) ||
                     (m == clock_mode_pkg::medium_gain_crystal_mode) ||
                     (m == clock_mode_pkg::high_gain_crystal_mode);
    endfunction : is_crystal

    function automatic logic has_clock_out(input clock_mode_pkg::clock_mode_t m);
        has_clock_out = (m == clock_mode_pkg::rc_with_clock_out_mode) ||
                        (m == clock_mode_pkg::internal_with_clock_out_mode);
    endfunction : has_clock_out

    // Reset release synchronisers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n <= rst_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge por_bor_rst_n) begin
        if (!por_bor_rst_n) begin
            por_meta_reg <= 1'b0;
            por_sync_n <= 1'b0;
        end else begin
            por_meta_reg <= 1'b1;
            por_sync_n <= por_meta_reg;
        end
    end

    // Oscillator pin synchroniser and edge detect
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            first_oscillator_pin_meta_reg <= 1'b0;
            first_oscillator_pin_sync_reg <= 1'b0;
            first_oscillator_pin_prev_reg <= 1'b0;
        end else begin
            first_oscillator_pin_meta_reg <= first_oscillator_pin_in;
            first_oscillator_pin_sync_reg <= first_oscillator_pin_meta_reg;
            first_oscillator_pin_prev_reg <= first_oscillator_pin_sync_reg;
        end
    end

    assign first_oscillator_pin_edge = first_oscillator_pin_sync_reg & ~first_oscillator_pin_prev_reg;

    // Capture configuration word after reset release
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg_valid_reg <= 1'b0;
            mode_reg <= clock_mode_pkg::external_clock_mode;
            freq_sel_reg <= 1'b0;
        end else if (!cfg_valid_reg) begin
            cfg_valid_reg <= 1'b1;
            mode_reg <= decode_mode(cfg_word[`CFG_MODE_MSB:`CFG_MODE_LSB]);
            freq_sel_reg <= cfg_word[`CFG_FREQ_BIT];
        end
    end

    assign cfg_load = rst_sync_n & ~cfg_valid_reg;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sleep_prev_reg <= 1'b0;
        end else begin
            sleep_prev_reg <= sleep_active;
        end
    end

    assign wake = sleep_prev_reg & ~sleep_active;

    // Timer restarts on reset release and wake
    start_up_timer u_start_up_timer (
        .clk(clk),
        .rst_n(rst_sync_n),
        .restart(cfg_load | wake),
        .osc_edge(first_oscillator_pin_edge),
        .done(startup_done)
    );

    assign div_run = cfg_valid_reg & has_clock_out(mode_reg);

    clock_out_divider u_clock_out_divider (
        .clk(clk),
        .rst_n(rst_sync_n),
        .run(div_run),
        .clk_out(clk_div4)
    );

    // Execution gate, bypass outside crystal modes
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            exec_enable <= 1'b0;
        end else begin
            exec_enable <= cfg_valid_reg && !sleep_active &&
                           (!is_crystal(mode_reg) || (startup_done && !wake));
        end
    end

    // Static pin roles, held while the clock stops
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sys_clk_src <= clock_mode_pkg::source_pin;
            amp_gain <= clock_mode_pkg::gain_off;
            int_osc_en <= 1'b0;
            int_8mhz <= 1'b0;
            first_oscillator_pin_gpio_en <= 1'b0;
            second_oscillator_pin_gpio_en <= 1'b0;
        end else if (cfg_valid_reg) begin
            int_8mhz <= freq_sel_reg;
            unique case (mode_reg)
                clock_mode_pkg::external_clock_mode: begin
                    sys_clk_src <= clock_mode_pkg::source_pin;
                    amp_gain <= clock_mode_pkg::gain_off;
                    int_osc_en <= 1'b0;
                    first_oscillator_pin_gpio_en <= 1'b0;
                    second_oscillator_pin_gpio_en <= 1'b1;
                end
                clock_mode_pkg::low_power_crystal_mode,
                clock_mode_pkg::medium_gain_crystal_mode,
                clock_mode_pkg::high_gain_crystal_mode: begin
                    sys_clk_src <= clock_mode_pkg::source_crystal;
                    amp_gain <= (mode_reg == clock_mode_pkg::low_power_crystal_mode) ?
                                clock_mode_pkg::gain_low :
                                (mode_reg == clock_mode_pkg::medium_gain_crystal_mode) ?
                                clock_mode_pkg::gain_medium : clock_mode_pkg::gain_high;
                    int_osc_en <= 1'b0;
                    first_oscillator_pin_gpio_en <= 1'b0;
                    second_oscillator_pin_gpio_en <= 1'b0;
                end
                // RC with clock out, RC with I/O
                clock_mode_pkg::rc_with_clock_out_mode,
                clock_mode_pkg::rc_with_io_mode: begin
                    sys_clk_src <= clock_mode_pkg::source_rc;
                    amp_gain <= clock_mode_pkg::gain_off;
                    int_osc_en <= 1'b0;
                    first_oscillator_pin_gpio_en <= 1'b0;
                    second_oscillator_pin_gpio_en <= (mode_reg == clock_mode_pkg::rc_with_io_mode);
                end
                // Internal with clock out, internal with I/O
                clock_mode_pkg::internal_with_clock_out_mode,
                clock_mode_pkg::internal_with_io_mode: begin
                    sys_clk_src <= clock_mode_pkg::source_internal;
                    amp_gain <= clock_mode_pkg::gain_off;
                    int_osc_en <= 1'b1;
                    first_oscillator_pin_gpio_en <= 1'b1;
                    second_oscillator_pin_gpio_en <= (mode_reg == clock_mode_pkg::internal_with_io_mode);
                end
            endcase
        end
    end

    // Second pin drives the divided clock
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            second_oscillator_pin_out <= 1'b0;
            second_oscillator_pin_oe_n <= 1'b1;
        end else begin
            second_oscillator_pin_out <= clk_div4;
            second_oscillator_pin_oe_n <= !div_run;
        end
    end

    // Trim reset only by power-on or brown-out
    always_ff @(posedge clk or negedge por_sync_n) begin
        if (!por_sync_n) begin
            trim_value <= `TRIM_RESET;
            trim_level <= `TRIM_LEVEL_RESET;
        end else if (rst_sync_n && reg_wr && reg_addr == `TRIM_ADDR) begin
            trim_value <= reg_wdata[`TRIM_WIDTH-1:0];
            trim_level <= {~reg_wdata[`TRIM_SIGN_BIT], reg_wdata[`TRIM_SIGN_BIT-1:0]};
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `TRIM_ADDR: reg_rdata <= {3'h0, trim_value};
                `STATUS_ADDR: reg_rdata <= {int_8mhz, exec_enable, startup_done,
                                            amp_gain, mode_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    property p_ec_pins;
        @(posedge clk) disable iff (!rst_sync_n)
        cfg_valid_reg && mode_reg == clock_mode_pkg::external_clock_mode |=>
            second_oscillator_pin_gpio_en && !first_oscillator_pin_gpio_en && sys_clk_src == clock_mode_pkg::source_pin;
    endproperty
    a_ec_pins: assert property (p_ec_pins)
        else $error("external clock mode pin roles wrong");

    property p_ec_no_delay;
        @(posedge clk) disable iff (!rst_sync_n)
        cfg_valid_reg && mode_reg == clock_mode_pkg::external_clock_mode && !sleep_active
            |=> exec_enable;
    endproperty
    a_ec_no_delay: assert property (p_ec_no_delay)
        else $error("external clock mode delayed execution");

    property p_trim_static;
        @(posedge clk) disable iff (!por_sync_n)
        !(reg_wr && reg_addr == 8'h00) |=> $stable(trim_value);
    endproperty
    a_trim_static: assert property (p_trim_static)
        else $error("trim changed without a write");

    property p_gain;
        @(posedge clk) disable iff (!rst_sync_n)
        cfg_valid_reg && is_crystal(mode_reg) |=>
            amp_gain == clock_mode_pkg::amp_gain_t'($past(mode_reg[1:0]));
    endproperty
    a_gain: assert property (p_gain)
        else $error("crystal gain does not match mode");

    property p_rc_clock_out;
        @(posedge clk) disable iff (!rst_sync_n)
        cfg_valid_reg && mode_reg == clock_mode_pkg::rc_with_clock_out_mode |=>
            !second_oscillator_pin_oe_n && !second_oscillator_pin_gpio_en;
    endproperty
    a_rc_clock_out: assert property (p_rc_clock_out)
        else $error("rc clock out not driven on second pin");

    property p_rc_io;
        @(posedge clk) disable iff (!rst_sync_n)
        cfg_valid_reg && mode_reg == clock_mode_pkg::rc_with_io_mode |=>
            second_oscillator_pin_oe_n && second_oscillator_pin_gpio_en && !first_oscillator_pin_gpio_en;
    endproperty
    a_rc_io: assert property (p_rc_io)
        else $error("rc io mode pin roles wrong");

    property p_int_io;
        @(posedge clk) disable iff (!rst_sync_n)
        cfg_valid_reg && mode_reg == clock_mode_pkg::internal_with_io_mode |=>
            first_oscillator_pin_gpio_en && second_oscillator_pin_gpio_en && int_osc_en && int_8mhz == $past(freq_sel_reg);
    endproperty
    a_int_io: assert property (p_int_io)
        else $error("internal io mode pin roles wrong");

    property p_trim_write;
        @(posedge clk) disable iff (!rst_sync_n)
        reg_wr && reg_addr == 8'h00 |=> trim_value == $past(reg_wdata[4:0]) &&
            trim_level == ($past(reg_wdata[4:0]) ^ 5'h10);
    endproperty
    a_trim_write: assert property (p_trim_write)
        else $error("trim write not applied next cycle");

    property p_trim_read;
        @(posedge clk) disable iff (!rst_sync_n)
        reg_rd && reg_addr == 8'h00 |=> reg_rdata == {3'h0, trim_value};
    endproperty
    a_trim_read: assert property (p_trim_read)
        else $error("trim readback wrong or upper bits set");

endmodule : clock_mode_select
`default_nettype wire

// ---- clock_out_divider.sv ----
// Divide-by-four clock output with even duty cycle.
// Assumes clk is the selected system clock.
`timescale 1ns/100ps
`default_nettype none
`include "clock_mode_cfg.svh"

module clock_out_divider (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output var logic clk_out
);

    logic [`DIV_CNT_W-1:0] cnt_reg;
    logic [`DIV_CNT_W-1:0] cnt_next;

    assign cnt_next = cnt_reg + 2'h1;

    // Two-bit divider, output follows the next count so the first period is even
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            clk_out <= 1'b0;
        end else if (!run) begin
            cnt_reg <= '0;
            clk_out <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            clk_out <= cnt_next[1];
        end
    end

    property p_half_period_two;
        @(posedge clk) disable iff (!rst_n)
        run [*5] |-> (clk_out != $past(clk_out, 2)) && (clk_out == $past(clk_out, 4));
    endproperty
    a_half_period_two: assert property (p_half_period_two)
        else $error("divided clock is not a quarter of the system clock");

endmodule : clock_out_divider
`default_nettype wire

// ---- osc_source.sv ----
// Behavioural far side: crystal, resonator, RC network or clock source.
// Assumes a 1 ns unit; the bench sets run and the half period.
`timescale 1ns/100ps
`default_nettype none

module osc_source (
    input wire logic run,
    input wire logic [15:0] half_ns,
    output var logic osc,
    output var logic [15:0] n_edges
);
    // Oscillates only while run is high, stands still otherwise
    initial begin
        osc = 1'b0;
        n_edges = 16'h0000;
        forever begin
            if (run) begin
                #(half_ns);
                osc = 1'b1;
                n_edges = n_edges + 16'h0001;
                #(half_ns);
                osc = 1'b0;
            end else begin
                #10;
            end
        end
    end

endmodule : osc_source

`default_nettype wire

// ---- start_up_timer.sv ----
// Start-up timer counting oscillator edges before execution may begin.
// Assumes osc_edge is a one-cycle pulse already synchronised to clk.
`timescale 1ns/100ps
`default_nettype none
`include "clock_mode_cfg.svh"

module start_up_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic osc_edge,
    output var logic done
);

    logic [`STARTUP_CNT_W-1:0] count_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
            done <= 1'b0;
        end else if (restart) begin
            count_reg <= '0;
            done <= 1'b0;
        end else if (!done && osc_edge) begin
            count_reg <= count_reg + 11'h001;
            if (count_reg == `STARTUP_LAST) begin
                done <= 1'b1;
            end
        end
    end

    property p_done_after_last;
        @(posedge clk) disable iff (!rst_n)
        $rose(done) |-> ($past(count_reg) == `STARTUP_LAST) && $past(osc_edge);
    endproperty
    a_done_after_last: assert property (p_done_after_last)
        else $error("start-up done without 1024 oscillator edges");

    property p_restart_clears;
        @(posedge clk) disable iff (!rst_n)
        restart |=> !done && (count_reg == 11'h000);
    endproperty
    a_restart_clears: assert property (p_restart_clears)
        else $error("start-up timer not cleared by restart");

endmodule : start_up_timer
`default_nettype wire

// ---- test_system_clock_mode_select.sv ----
// Self-checking bench for the clock mode selection block.
// Assumes the design files and osc_source are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "clock_mode_cfg.svh"

module test_system_clock_mode_select;
    logic clk, clk_hold, rst_n, por_bor_rst_n, first_oscillator_pin, osc_run, sleep_active;
    logic reg_wr, reg_rd, int_osc_en, int_8mhz, first_oscillator_pin_gpio_en, second_oscillator_pin_gpio_en;
    logic second_oscillator_pin_out, second_oscillator_pin_oe_n, exec_enable;
    logic [7:0] cfg_word, reg_addr, reg_wdata, reg_rdata, rd_data, d, smp;
    logic [1:0] sys_clk_src, amp_gain;
    logic [4:0] trim_value, trim_level;
    logic [15:0] half_ns, n_edges, base;
    logic [8:0] pe;
    integer seed, n_fail, n_compared, k, m;

    clock_mode_select dut (.clk(clk), .rst_n(rst_n), .por_bor_rst_n(por_bor_rst_n),
        .cfg_word(cfg_word), .first_oscillator_pin_in(first_oscillator_pin), .sleep_active(sleep_active),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sys_clk_src(sys_clk_src), .amp_gain(amp_gain),
        .int_osc_en(int_osc_en), .int_8mhz(int_8mhz), .trim_value(trim_value),
        .trim_level(trim_level), .first_oscillator_pin_gpio_en(first_oscillator_pin_gpio_en),
        .second_oscillator_pin_gpio_en(second_oscillator_pin_gpio_en), .second_oscillator_pin_out(second_oscillator_pin_out), .second_oscillator_pin_oe_n(second_oscillator_pin_oe_n),
        .exec_enable(exec_enable));

    osc_source far (.run(osc_run), .half_ns(half_ns), .osc(first_oscillator_pin), .n_edges(n_edges));

    initial begin
        clk = 1'b0;
        forever begin
            #25;
            if (!clk_hold) clk = ~clk;
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task close_out;
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task tick(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task do_reset(input logic por, input logic [7:0] cfg);
        @(posedge clk);
        rst_n <= 1'b0;
        por_bor_rst_n <= ~por;
        cfg_word <= cfg;
        tick(4);
        @(posedge clk);
        rst_n <= 1'b1;
        por_bor_rst_n <= 1'b1;
        tick(8);
    endtask : do_reset

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd_data = reg_rdata;
    endtask : rd

    task wait_exec;
        for (k = 0; k < 20000 && exec_enable !== 1'b1; k++) tick(1);
        if (exec_enable !== 1'b1) begin
            n_fail = n_fail + 1;
            close_out;
        end
    endtask : wait_exec

    // Bits: source, gain, first gpio, second gpio, oe_n, internal, exec
    function automatic logic [8:0] exp_pins(input logic [2:0] mode);
        case (mode)
            3'h0: exp_pins = 9'b000001101;
            3'h1: exp_pins = 9'b010100100;
            3'h2: exp_pins = 9'b011000100;
            3'h3: exp_pins = 9'b011100100;
            3'h4: exp_pins = 9'b100000001;
            3'h5: exp_pins = 9'b100001101;
            3'h6: exp_pins = 9'b110010011;
            default: exp_pins = 9'b110011111;
        endcase
    endfunction : exp_pins

    initial begin
        #3000000;
        n_fail = n_fail + 1;
        close_out;
    end

    initial begin
        seed = 32'h5677;
        n_fail = 0;
        n_compared = 0;
        clk_hold = 1'b0;
        rst_n = 1'b0;
        por_bor_rst_n = 1'b0;
        cfg_word = 8'h00;
        sleep_active = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        osc_run = 1'b0;
        half_ns = 16'h00a0;
        // Every mode code, random spare bits
        for (m = 0; m < 8; m++) begin
            d = $random(seed);
            do_reset(1'b1, {d[7:3], m[2:0]});
            pe = exp_pins(m[2:0]);
            chk({sys_clk_src, amp_gain, first_oscillator_pin_gpio_en, second_oscillator_pin_gpio_en, second_oscillator_pin_oe_n,
                int_osc_en, exec_enable}, pe);
            if (m >= 6) chk(int_8mhz, d[7]);
            rd(`STATUS_ADDR);
            chk({rd_data[6], rd_data[4:0]}, {pe[0], pe[6:5], m[2:0]});
            if (m == 4 || m == 6) begin
                for (k = 0; k < 8; k++) begin
                    tick(1);
                    smp[k] = second_oscillator_pin_out;
                end
                for (k = 0; k < 4; k++) chk({smp[k], smp[k]}, {smp[k + 4], ~smp[k + 2]});
            end
            if (m == 0) begin
                @(posedge clk);
                sleep_active <= 1'b1;
                tick(3);
                @(posedge clk);
                sleep_active <= 1'b0;
                tick(3);
                chk(exec_enable, 1'b1);
            end
        end
        do_reset(1'b1, 8'h00);
        chk({trim_value, trim_level}, 10'h010);
        for (m = 0; m < 24; m++) begin
            d = (m == 0) ? 8'h0f : (m == 1) ? 8'h10 : (m == 2) ? 8'hff : $random(seed);
            wr(`TRIM_ADDR, d);
            chk({trim_value, trim_level}, {d[4:0], d[4:0] ^ 5'h10});
            chk(exec_enable, 1'b1);
            rd(`TRIM_ADDR);
            chk(rd_data, {3'b000, d[4:0]});
        end
        d = 8'h1b;
        wr(`TRIM_ADDR, d);
        wr(8'h05, 8'h0a);
        rd(8'h02);
        chk({rd_data, 3'b000, trim_value}, {8'h00, 3'b000, d[4:0]});
        @(negedge clk);
        clk_hold = 1'b1;
        #1010;
        clk_hold = 1'b0;
        rd(`TRIM_ADDR);
        chk({rd_data, 7'h00, exec_enable}, {3'b000, d[4:0], 8'h01});
        do_reset(1'b0, 8'h00);
        chk(trim_value, d[4:0]);
        do_reset(1'b1, 8'h00);
        chk({trim_value, trim_level}, 10'h010);
        // Crystal start-up, then wake with a slow crystal
        do_reset(1'b1, 8'h03);
        chk(exec_enable, 1'b0);
        base = n_edges;
        osc_run = 1'b1;
        wait_exec;
        chk(n_edges - base, 16'h0400);
        osc_run = 1'b0;
        @(posedge clk);
        sleep_active <= 1'b1;
        tick(30);
        chk(exec_enable, 1'b0);
        half_ns = 16'h014a;
        @(posedge clk);
        sleep_active <= 1'b0;
        tick(1);
        chk(exec_enable, 1'b0);
        tick(3);
        base = n_edges;
        osc_run = 1'b1;
        wait_exec;
        chk(n_edges - base, 16'h0400);
        close_out;
    end

endmodule : test_system_clock_mode_select

`default_nettype wire
